// ### src/mts_pkg.sv
// constants for the module temperature sensor register block
package mts_pkg;
   // ***********************************************************
   // register pointer codes
   // ***********************************************************
   localparam logic [2:0] PTR_CAP   = 3'h0;
   localparam logic [2:0] PTR_CFG   = 3'h1;
   localparam logic [2:0] PTR_UPPER = 3'h2;
   localparam logic [2:0] PTR_LOWER = 3'h3;
   localparam logic [2:0] PTR_CRIT  = 3'h4;
   localparam logic [2:0] PTR_TEMP  = 3'h5;
   // ***********************************************************
   // capability value and fields
   // ***********************************************************
   localparam logic [15:0] CAP_VALUE = 16'h0001;
   localparam int CAP_WIDE   = 2;
   localparam int CAP_RES_LO = 3;
   localparam int CAP_RES_HI = 4;
   // ***********************************************************
   // configuration fields
   // ***********************************************************
   localparam int CFG_MODE       = 0;
   localparam int CFG_POL        = 1;
   localparam int CFG_CRIT_ONLY  = 2;
   localparam int CFG_OUT_EN     = 3;
   localparam int CFG_STATUS     = 4;
   localparam int CFG_CLEAR      = 5;
   localparam int CFG_ALARM_LOCK = 6;
   localparam int CFG_CRIT_LOCK  = 7;
   localparam int CFG_SHUTDOWN   = 8;
   localparam int CFG_HYST_LO    = 9;
   localparam int CFG_HYST_HI    = 10;
   // ***********************************************************
   // bound and readout layout
   // ***********************************************************
   localparam int BND_MSB   = 12;
   localparam int BND_LSB   = 2;
   localparam int BND_W     = 11;
   localparam int TEMP_W    = 13;
   localparam int RD_BELOW  = 13;
   localparam int RD_ABOVE  = 14;
   localparam int RD_CRIT   = 15;
   // hysteresis in sixteenths of a degree
   localparam logic signed [13:0] HYST_1P5 = 14'sh0018;
   localparam logic signed [13:0] HYST_3   = 14'sh0030;
   localparam logic signed [13:0] HYST_6   = 14'sh0060;
   // ***********************************************************
   // bus framing
   // ***********************************************************
   localparam logic [3:0] SLAVE_BASE = 4'h3;
   localparam logic [3:0] BIT_LAST   = 4'h8;
   localparam logic [1:0] BYTE_PTR   = 2'h0;
   localparam logic [1:0] BYTE_HI    = 2'h1;
   localparam logic [1:0] BYTE_LO    = 2'h2;
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_ADDR  = 2'b01,
      ST_WRITE = 2'b11,
      ST_READ  = 2'b10
   } mts_state_type;
endpackage

// ### src/mts_temp_sensor_regs.sv
// serial-bus temperature sensor registers with event pin
`timescale 1ns/1ps
`default_nettype none
// Contract
// - pointer byte selects target register
// - pointer codes zero to five decode registers
// - capability read-only, bit zero set
// - capability bit one gives accuracy class
// - capability bit two clear clamps negatives
// - bits 4:3 resolution, upper bits zero
// - mode bit ignored while locked
// - polarity bit ignored while locked
// - bit two limits events to critical
// - bit three gates event output
// - status bit shows event asserted
// - clear bit drops interrupt event
// - lock bits protect bound registers
// - shutdown freezes temperature sensing
// - bits 10:9 pick hysteresis
// - window flags with hysteresis thresholds
// - temperatures held two's complement
// - bounds quarter degree, bits 12:2
// - critical limit quarter degree, reserved zero
// - readout read-only, half degree steps
// - readout top bits flag trips
// - comparator event not software clearable
// - critical event stays until cooled
// - address 0011 plus subaddress pins
module mts_temp_sensor_regs (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        sclIn,
   input  wire logic        sdaIn,
   output logic             sdaOut,
   output logic             sdaOe,
   input  wire logic [2:0]  subAddr,
   input  wire logic [12:0] sensorTemp,
   output logic             eventOut,
   output logic             eventOe
);
   // ***********************************************************
   // pin synchronisers
   // ***********************************************************
   logic [2:0] sclSync_reg;
   logic [2:0] sdaSync_reg;
   logic [2:0] addrMeta_reg;
   logic [2:0] addrSync_reg;
   always_ff @(posedge clock or posedge rst)
      if (rst)
      begin
         sclSync_reg  <= 3'h7;
         sdaSync_reg  <= 3'h7;
         addrMeta_reg <= 3'h0;
         addrSync_reg <= 3'h0;
      end
      else
      begin
         sclSync_reg  <= {sclSync_reg[1:0], sclIn};
         sdaSync_reg  <= {sdaSync_reg[1:0], sdaIn};
         addrMeta_reg <= subAddr;
         addrSync_reg <= addrMeta_reg;
      end
   logic sclRise, sclFall, busStart, busStop, sdaBit;
   assign sdaBit   = sdaSync_reg[1];
   assign sclRise  = sclSync_reg[1] & ~sclSync_reg[2];
   assign sclFall  = ~sclSync_reg[1] & sclSync_reg[2];
   assign busStart = sclSync_reg[1] & sclSync_reg[2] & ~sdaBit
                     & sdaSync_reg[2];
   assign busStop  = sclSync_reg[1] & sclSync_reg[2] & sdaBit
                     & ~sdaSync_reg[2];
   // ***********************************************************
   // bus slave
   // ***********************************************************
   mts_pkg::mts_state_type state_reg;
   logic [3:0]  bitCnt_reg;
   logic        ackSlot_reg;
   logic [7:0]  rxByte_reg;
   logic [7:0]  txByte_reg;
   logic [7:0]  rdLow_reg;
   logic [7:0]  dataHi_reg;
   logic [1:0]  byteIdx_reg;
   logic [2:0]  ptr_reg;
   logic        readLow_reg;
   logic        sdaOe_reg;
   logic [15:0] rdWord;
   logic        byteDone;
   logic        wrEn;
   logic [15:0] wrData;
   assign byteDone = sclFall & ~ackSlot_reg & (bitCnt_reg == mts_pkg::BIT_LAST)
                     & ~busStart & ~busStop;
   // low byte completes a word write
   assign wrEn   = byteDone & (state_reg == mts_pkg::ST_WRITE)
                   & (byteIdx_reg == mts_pkg::BYTE_LO);
   assign wrData = {dataHi_reg, rxByte_reg};
   always_ff @(posedge clock or posedge rst)
      if (rst)
      begin
         state_reg   <= mts_pkg::ST_IDLE;
         bitCnt_reg  <= 4'h0;
         ackSlot_reg <= 1'b0;
         rxByte_reg  <= 8'h00;
         txByte_reg  <= 8'h00;
         rdLow_reg   <= 8'h00;
         dataHi_reg  <= 8'h00;
         byteIdx_reg <= mts_pkg::BYTE_PTR;
         ptr_reg     <= mts_pkg::PTR_CAP;
         readLow_reg <= 1'b0;
         sdaOe_reg   <= 1'b0;
      end
      else if (busStart)
      begin
         state_reg   <= mts_pkg::ST_ADDR;
         bitCnt_reg  <= 4'h0;
         ackSlot_reg <= 1'b0;
         byteIdx_reg <= mts_pkg::BYTE_PTR;
         readLow_reg <= 1'b0;
         sdaOe_reg   <= 1'b0;
      end
      else if (busStop)
      begin
         state_reg <= mts_pkg::ST_IDLE;
         sdaOe_reg <= 1'b0;
      end
      else if (state_reg != mts_pkg::ST_IDLE)
      begin
         if (sclRise)
         begin
            if (!ackSlot_reg)
            begin
               rxByte_reg <= {rxByte_reg[6:0], sdaBit};
               bitCnt_reg <= bitCnt_reg + 4'h1;
            end
            // host nack ends a read
            else if (state_reg == mts_pkg::ST_READ && sdaBit)
               state_reg <= mts_pkg::ST_IDLE;
         end
         else if (sclFall && ackSlot_reg)
         begin
            ackSlot_reg <= 1'b0;
            bitCnt_reg  <= 4'h0;
            sdaOe_reg   <= 1'b0;
            // high byte first, low byte latched
            if (state_reg == mts_pkg::ST_READ)
            begin
               readLow_reg <= ~readLow_reg;
               if (!readLow_reg)
               begin
                  txByte_reg <= rdWord[15:8];
                  rdLow_reg  <= rdWord[7:0];
                  sdaOe_reg  <= ~rdWord[15];
               end
               else
               begin
                  txByte_reg <= rdLow_reg;
                  sdaOe_reg  <= ~rdLow_reg[7];
               end
            end
         end
         else if (byteDone)
         begin
            ackSlot_reg <= 1'b1;
            unique case (state_reg)
               mts_pkg::ST_ADDR:
                  if (rxByte_reg[7:1] == {mts_pkg::SLAVE_BASE, addrSync_reg})
                  begin
                     sdaOe_reg <= 1'b1;
                     state_reg <= rxByte_reg[0] ? mts_pkg::ST_READ
                                                : mts_pkg::ST_WRITE;
                  end
                  else
                     state_reg <= mts_pkg::ST_IDLE;
               // first written byte is the pointer
               mts_pkg::ST_WRITE:
               begin
                  sdaOe_reg <= 1'b1;
                  unique case (byteIdx_reg)
                     mts_pkg::BYTE_PTR:
                     begin
                        ptr_reg     <= rxByte_reg[2:0];
                        byteIdx_reg <= mts_pkg::BYTE_HI;
                     end
                     mts_pkg::BYTE_HI:
                     begin
                        dataHi_reg  <= rxByte_reg;
                        byteIdx_reg <= mts_pkg::BYTE_LO;
                     end
                     default:
                        byteIdx_reg <= mts_pkg::BYTE_HI;
                  endcase
               end
               mts_pkg::ST_READ:
                  sdaOe_reg <= 1'b0;
               mts_pkg::ST_IDLE:
                  sdaOe_reg <= 1'b0;
            endcase
         end
         else if (sclFall && state_reg == mts_pkg::ST_READ)
         begin
            txByte_reg <= {txByte_reg[6:0], 1'b0};
            sdaOe_reg  <= ~txByte_reg[6];
         end
      end
   // ***********************************************************
   // configuration register
   // ***********************************************************
   logic       cfgMode_reg, cfgPol_reg, cfgCritOnly_reg, cfgOutEn_reg;
   logic       cfgAlarmLock_reg, cfgCritLock_reg, cfgShut_reg;
   logic [1:0] cfgHyst_reg;
   logic       cfgWr, anyLock;
   assign cfgWr   = wrEn & (ptr_reg == mts_pkg::PTR_CFG);
   assign anyLock = cfgAlarmLock_reg | cfgCritLock_reg;
   always_ff @(posedge clock or posedge rst)
      if (rst)
      begin
         cfgMode_reg      <= 1'b0;
         cfgPol_reg       <= 1'b0;
         cfgCritOnly_reg  <= 1'b0;
         cfgOutEn_reg     <= 1'b0;
         cfgAlarmLock_reg <= 1'b0;
         cfgCritLock_reg  <= 1'b0;
         cfgShut_reg      <= 1'b0;
         cfgHyst_reg      <= 2'h0;
      end
      else if (cfgWr)
      begin
         if (!anyLock)
         begin
            cfgMode_reg <= wrData[mts_pkg::CFG_MODE];
            cfgPol_reg  <= wrData[mts_pkg::CFG_POL];
         end
         cfgCritOnly_reg  <= wrData[mts_pkg::CFG_CRIT_ONLY];
         cfgOutEn_reg     <= wrData[mts_pkg::CFG_OUT_EN];
         cfgAlarmLock_reg <= wrData[mts_pkg::CFG_ALARM_LOCK];
         cfgCritLock_reg  <= wrData[mts_pkg::CFG_CRIT_LOCK];
         cfgShut_reg      <= wrData[mts_pkg::CFG_SHUTDOWN];
         cfgHyst_reg <= wrData[mts_pkg::CFG_HYST_HI:mts_pkg::CFG_HYST_LO];
      end
   // ***********************************************************
   // trip point registers
   // ***********************************************************
   logic [10:0] upper_reg, lower_reg, crit_reg;
   logic [10:0] wrBound;
   assign wrBound = wrData[mts_pkg::BND_MSB:mts_pkg::BND_LSB];
   always_ff @(posedge clock or posedge rst)
      if (rst)
      begin
         upper_reg <= 11'h000;
         lower_reg <= 11'h000;
         crit_reg  <= 11'h000;
      end
      else
      begin
         if (wrEn && !cfgAlarmLock_reg && ptr_reg == mts_pkg::PTR_UPPER)
            upper_reg <= wrBound;
         if (wrEn && !cfgAlarmLock_reg && ptr_reg == mts_pkg::PTR_LOWER)
            lower_reg <= wrBound;
         if (wrEn && !cfgCritLock_reg && ptr_reg == mts_pkg::PTR_CRIT)
            crit_reg <= wrBound;
      end
   // ***********************************************************
   // temperature capture and trip flags
   // ***********************************************************
   function automatic logic [12:0] shapeTemp(input logic [12:0] t);
      logic [1:0]  res;
      logic [12:0] v;
      res = mts_pkg::CAP_VALUE[mts_pkg::CAP_RES_HI:mts_pkg::CAP_RES_LO];
      v   = t;
      unique case (res)
         2'h0: v[2:0] = 3'h0;
         2'h1: v[1:0] = 2'h0;
         2'h2: v[0]   = 1'b0;
         2'h3: v      = t;
      endcase
      if (!mts_pkg::CAP_VALUE[mts_pkg::CAP_WIDE] && t[12])
         v = 13'h0000;
      return v;
   endfunction
   function automatic logic signed [13:0] toFine(input logic [10:0] b);
      return {b[10], b, 2'b00};
   endfunction
   logic [12:0] temp_reg;
   logic        above_reg, below_reg, critFlag_reg;
   logic signed [13:0] tNow, hyst;
   assign tNow = {temp_reg[12], temp_reg};
   always_comb
      unique case (cfgHyst_reg)
         2'h0: hyst = 14'sh0000;
         2'h1: hyst = mts_pkg::HYST_1P5;
         2'h2: hyst = mts_pkg::HYST_3;
         2'h3: hyst = mts_pkg::HYST_6;
      endcase
   always_ff @(posedge clock or posedge rst)
      if (rst)
      begin
         temp_reg     <= 13'h0000;
         above_reg    <= 1'b0;
         below_reg    <= 1'b0;
         critFlag_reg <= 1'b0;
      end
      else if (!cfgShut_reg)
      begin
         temp_reg <= shapeTemp(sensorTemp);
         above_reg <= above_reg ? (tNow > toFine(upper_reg) - hyst)
                                : (tNow > toFine(upper_reg));
         below_reg <= below_reg ? (tNow < toFine(lower_reg))
                                : (tNow < toFine(lower_reg) - hyst);
         critFlag_reg <= critFlag_reg ? (tNow >= toFine(crit_reg) - hyst)
                                      : (tNow >= toFine(crit_reg));
      end
   // ***********************************************************
   // event logic
   // ***********************************************************
   logic cond, condPrev_reg, evtLatch_reg, pending, clearWr;
   assign cond    = critFlag_reg | (~cfgCritOnly_reg & (above_reg | below_reg));
   // clear acts only in interrupt mode
   assign clearWr = cfgWr & wrData[mts_pkg::CFG_CLEAR] & cfgMode_reg;
   assign pending = cfgMode_reg ? (evtLatch_reg | critFlag_reg) : cond;
   always_ff @(posedge clock or posedge rst)
      if (rst)
      begin
         condPrev_reg <= 1'b0;
         evtLatch_reg <= 1'b0;
      end
      else
      begin
         condPrev_reg <= cond;
         if (cond && !condPrev_reg)
            evtLatch_reg <= 1'b1;
         else if (clearWr)
            evtLatch_reg <= 1'b0;
      end
   logic eventOe_reg, eventOut_reg, sdaOut_reg;
   always_ff @(posedge clock or posedge rst)
      if (rst)
      begin
         eventOe_reg  <= 1'b0;
         eventOut_reg <= 1'b0;
         sdaOut_reg   <= 1'b0;
      end
      else
      begin
         eventOe_reg  <= cfgOutEn_reg & pending;
         eventOut_reg <= cfgPol_reg;
         sdaOut_reg   <= 1'b0;
      end
   assign eventOe  = eventOe_reg;
   assign eventOut = eventOut_reg;
   assign sdaOe    = sdaOe_reg;
   assign sdaOut   = sdaOut_reg;
   // ***********************************************************
   // read mux
   // ***********************************************************
   // pointer decode
   always_comb
   begin
      rdWord = 16'h0000;
      case (ptr_reg)
         mts_pkg::PTR_CAP: rdWord = mts_pkg::CAP_VALUE;
         mts_pkg::PTR_CFG:
         begin
            rdWord[mts_pkg::CFG_MODE]       = cfgMode_reg;
            rdWord[mts_pkg::CFG_POL]        = cfgPol_reg;
            rdWord[mts_pkg::CFG_CRIT_ONLY]  = cfgCritOnly_reg;
            rdWord[mts_pkg::CFG_OUT_EN]     = cfgOutEn_reg;
            rdWord[mts_pkg::CFG_STATUS]     = eventOe_reg;
            rdWord[mts_pkg::CFG_ALARM_LOCK] = cfgAlarmLock_reg;
            rdWord[mts_pkg::CFG_CRIT_LOCK]  = cfgCritLock_reg;
            rdWord[mts_pkg::CFG_SHUTDOWN]   = cfgShut_reg;
            rdWord[mts_pkg::CFG_HYST_HI:mts_pkg::CFG_HYST_LO] = cfgHyst_reg;
         end
         mts_pkg::PTR_UPPER:
            rdWord[mts_pkg::BND_MSB:mts_pkg::BND_LSB] = upper_reg;
         mts_pkg::PTR_LOWER:
            rdWord[mts_pkg::BND_MSB:mts_pkg::BND_LSB] = lower_reg;
         mts_pkg::PTR_CRIT:
            rdWord[mts_pkg::BND_MSB:mts_pkg::BND_LSB] = crit_reg;
         mts_pkg::PTR_TEMP:
            rdWord = {critFlag_reg, above_reg, below_reg, temp_reg};
         default: rdWord = 16'h0000;
      endcase
   end
   // ***********************************************************
   // assertions
   // ***********************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   a_mode_lock: assert property (cfgWr && anyLock |=> $stable(cfgMode_reg))
      else $error("mode changed while locked");
   a_pol_lock: assert property (cfgWr && anyLock |=> $stable(cfgPol_reg))
      else $error("polarity changed while locked");
   a_bound_lock: assert property (cfgAlarmLock_reg |=> $stable(upper_reg)
      && $stable(lower_reg))
      else $error("alarm bound changed while locked");
   a_crit_lock: assert property (cfgCritLock_reg |=> $stable(crit_reg))
      else $error("critical limit changed while locked");
   a_out_gate: assert property (!cfgOutEn_reg |=> !eventOe)
      else $error("event driven while disabled");
   a_cmp_release: assert property (!cfgMode_reg && !cond |=> !eventOe)
      else $error("comparator event held without condition");
   a_crit_hold: assert property (critFlag_reg && cfgOutEn_reg |=> eventOe)
      else $error("critical event not driven");
   a_event_level: assert property (eventOe |-> eventOut == $past(cfgPol_reg))
      else $error("event level differs from polarity");
   a_shut_freeze: assert property (cfgShut_reg |=> $stable(temp_reg))
      else $error("reading moved during shutdown");
   a_clamp_neg: assert property (!mts_pkg::CAP_VALUE[mts_pkg::CAP_WIDE]
      |-> !temp_reg[12])
      else $error("negative reading not clamped");
   a_clear_evt: assert property (clearWr && condPrev_reg |=> !evtLatch_reg)
      else $error("clear did not drop event");
   c_addr_ack: cover property (state_reg == mts_pkg::ST_ADDR ##1
      state_reg == mts_pkg::ST_WRITE);
   c_word_write: cover property (wrEn);
   c_read_word: cover property (state_reg == mts_pkg::ST_READ && readLow_reg);
   c_event_on: cover property (!eventOe ##1 eventOe);
endmodule // mts_temp_sensor_regs
`default_nettype wire

// ### test/mts_smbus_host.sv
// management bus host model driving the sensor's serial pins
`timescale 1ns/1ps
`default_nettype none
module mts_smbus_host (
   input  wire logic       clock,
   input  wire logic       sdaIn,
   input  wire logic [2:0] devSub,
   output logic            sclOut,
   output logic            sdaLow
);
   // ************
   // bit level
   // ************
   initial
   begin
      sclOut = 1'b1;
      sdaLow = 1'b0;
   end
   task automatic wt(input int n);
      repeat (n) @(negedge clock);
   endtask
   // bus clock stands high between frames
   task automatic xbit(input logic b, output logic r);
      wt(5);
      sdaLow = !b;
      wt(5);
      sclOut = 1'b1;
      wt(5);
      r = sdaIn;
      wt(5);
      sclOut = 1'b0;
   endtask
   task automatic start();
      sdaLow = 1'b0;
      wt(5);
      sclOut = 1'b1;
      wt(5);
      sdaLow = 1'b1;
      wt(5);
      sclOut = 1'b0;
   endtask
   task automatic stop();
      wt(5);
      sdaLow = 1'b1;
      wt(5);
      sclOut = 1'b1;
      wt(5);
      sdaLow = 1'b0;
      wt(10);
   endtask
   // ************
   // byte and word level
   // ************
   task automatic sendB(input logic [7:0] d, inout logic ok);
      logic r;
      for (int i = 7; i >= 0; i--)
         xbit(d[i], r);
      xbit(1'b1, r);
      ok = ok & !r;
   endtask
   task automatic recvB(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
         xbit(1'b1, d[i]);
      xbit(last, r);
   endtask
   task automatic wr(input logic [7:0] p, input logic [15:0] v,
                     output logic ok);
      ok = 1'b1;
      start();
      sendB({mts_pkg::SLAVE_BASE, devSub, 1'b0}, ok);
      sendB(p, ok);
      sendB(v[15:8], ok);
      sendB(v[7:0], ok);
      stop();
   endtask
   task automatic rd(input logic [7:0] p, output logic [15:0] v);
      logic ok;
      ok = 1'b1;
      start();
      sendB({mts_pkg::SLAVE_BASE, devSub, 1'b0}, ok);
      sendB(p, ok);
      start();
      sendB({mts_pkg::SLAVE_BASE, devSub, 1'b1}, ok);
      recvB(1'b0, v[15:8]);
      recvB(1'b1, v[7:0]);
      stop();
   endtask
endmodule // mts_smbus_host
`default_nettype wire

// ### test/tb_mts_temp_sensor_regs.sv
// self-checking bench for the sensor register block
`timescale 1ns/1ps
`default_nettype none
module tb_mts_temp_sensor_regs;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic [2:0]  hostSub = 3'h5;
   logic [2:0]  pinSub = 3'h5;
   logic [12:0] sensorTemp = 13'h0200;
   logic        scl;
   logic        hostLow;
   logic        sdaOut;
   logic        sdaOe;
   logic        eventOut;
   logic        eventOe;
   logic        sdaWire;
   int          n_mismatch = 0;
   int          check_count = 0;
   // pulled up unless a side pulls low
   assign sdaWire = !(hostLow || (sdaOe && !sdaOut));
   always #4 clock = !clock;
   mts_temp_sensor_regs i_dut (.clock(clock), .rst(rst), .sclIn(scl),
      .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe), .subAddr(pinSub),
      .sensorTemp(sensorTemp), .eventOut(eventOut), .eventOe(eventOe));
   mts_smbus_host i_host (.clock(clock), .sdaIn(sdaWire),
      .devSub(hostSub), .sclOut(scl), .sdaLow(hostLow));
   // ************
   // helpers
   // ************
   task automatic chk(input string nm, input logic [15:0] seen,
                      input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic wrc(input logic [2:0] p, input logic [15:0] v);
      logic ok;
      i_host.wr({5'h00, p}, v, ok);
      chk("ack", 16'(ok), 16'h0001);
   endtask
   task automatic rdc(input logic [2:0] p, input logic [15:0] e);
      logic [15:0] v;
      i_host.rd({5'h00, p}, v);
      chk($sformatf("reg%0d", p), v, e);
   endtask
   task automatic tmp(input logic [12:0] t, input logic [15:0] e);
      sensorTemp = t;
      i_host.wt(4);
      rdc(3'h5, e);
   endtask
   task automatic ev(input logic e);
      i_host.wt(6);
      chk("event", 16'(eventOe), 16'(e));
   endtask
   task automatic tev(input logic [12:0] t, input logic e);
      sensorTemp = t;
      ev(e);
   endtask
   // ************
   // scenarios
   // ************
   task automatic s_reset();
      for (int p = 0; p < 8; p++)
         if (p != 5)
            rdc(p[2:0], p == 0 ? 16'h0001 : 16'h0000);
   endtask
   task automatic s_regs();
      wrc(3'h0, 16'hFFFF);
      rdc(3'h0, 16'h0001);
      wrc(3'h2, 16'hFFFF);
      rdc(3'h2, 16'h1FFC);
      wrc(3'h4, 16'hFFFF);
      rdc(3'h4, 16'h1FFC);
      wrc(3'h2, 16'h0320);
      wrc(3'h3, 16'h0190);
      wrc(3'h4, 16'h0640);
      wrc(3'h5, 16'h0000);
      tmp(13'h0197, 16'h0190);
      tmp(13'h1E74, 16'h2000);
      tmp(13'h0640, 16'hC640);
   endtask
   task automatic s_hyst();
      logic [12:0] hy [4] = '{13'h0000, 13'h0018, 13'h0030, 13'h0060};
      for (int h = 0; h < 4; h++)
      begin
         wrc(3'h1, {5'h00, h[1:0], 9'h000});
         sensorTemp = 13'h0330;
         i_host.wt(4);
         tmp(13'h0328 - hy[h], {3'h2, 13'h0328 - hy[h]});
         tmp(13'h0320 - hy[h], {3'h0, 13'h0320 - hy[h]});
      end
      wrc(3'h1, 16'h0200);
      tmp(13'h0180, 16'h0180);
      tmp(13'h0170, 16'h2170);
      tmp(13'h0188, 16'h2188);
      tmp(13'h0190, 16'h0190);
   endtask
   task automatic s_cmp();
      wrc(3'h1, 16'h0008);
      tev(13'h0200, 1'b0);
      tev(13'h0330, 1'b1);
      chk("pol", 16'(eventOut), 16'h0000);
      rdc(3'h1, 16'h0018);
      wrc(3'h1, 16'h0028);
      ev(1'b1);
      wrc(3'h1, 16'h000A);
      chk("pol", 16'(eventOut), 16'h0001);
      tev(13'h0200, 1'b0);
      wrc(3'h1, 16'h0002);
      tev(13'h0330, 1'b0);
      tev(13'h0200, 1'b0);
   endtask
   task automatic s_int();
      wrc(3'h1, 16'h0009);
      // drop latch left over from comparator runs
      wrc(3'h1, 16'h0029);
      ev(1'b0);
      tev(13'h0330, 1'b1);
      tev(13'h0200, 1'b1);
      wrc(3'h1, 16'h0029);
      ev(1'b0);
      tev(13'h0640, 1'b1);
      wrc(3'h1, 16'h0029);
      ev(1'b1);
      sensorTemp = 13'h0200;
      wrc(3'h1, 16'h0029);
      ev(1'b0);
   endtask
   task automatic s_crit();
      wrc(3'h1, 16'h000C);
      tev(13'h0330, 1'b0);
      tev(13'h0640, 1'b1);
      tev(13'h0200, 1'b0);
   endtask
   task automatic s_shut();
      wrc(3'h1, 16'h0100);
      tmp(13'h0250, 16'h0200);
      wrc(3'h1, 16'h0000);
      tmp(13'h0250, 16'h0250);
   endtask
   task automatic s_lock();
      wrc(3'h1, 16'h0040);
      wrc(3'h2, 16'h0400);
      rdc(3'h2, 16'h0320);
      wrc(3'h4, 16'h0700);
      rdc(3'h4, 16'h0700);
      wrc(3'h1, 16'h0043);
      rdc(3'h1, 16'h0040);
      wrc(3'h1, 16'h0080);
      wrc(3'h4, 16'h0640);
      rdc(3'h4, 16'h0700);
      wrc(3'h3, 16'h0100);
      rdc(3'h3, 16'h0100);
   endtask
   task automatic s_addr();
      logic ok;
      hostSub = 3'h2;
      i_host.wr(8'h02, 16'h0400, ok);
      chk("nack", 16'(ok), 16'h0000);
      hostSub = 3'h5;
      rdc(3'h2, 16'h0320);
      // move the pins and follow them
      pinSub  = 3'h2;
      hostSub = 3'h2;
      wrc(3'h2, 16'h0400);
      rdc(3'h2, 16'h0400);
   endtask
   initial
   begin
      repeat (10) @(negedge clock);
      rst = 1'b0;
      i_host.wt(3);
      s_reset();
      s_regs();
      s_hyst();
      s_cmp();
      s_int();
      s_crit();
      s_shut();
      s_lock();
      s_addr();
      test_done();
   end
   initial
   begin
      #720000;
      n_mismatch++;
      test_done();
   end
endmodule // tb_mts_temp_sensor_regs
`default_nettype wire
